// ---- wdt_pkg.sv ----
package wdt_pkg;

  // ==========================================================
  // counter geometry and timing
  // ==========================================================
  localparam int COUNT_W = 24;
  localparam int PRESCALE = 4;
  localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE - 1);
  localparam logic [COUNT_W-1:0] TIMEOUT_MIN = 24'h0000FF;
  localparam logic [COUNT_W-1:0] TIMEOUT_RESET = 24'hFFFFFF;
  localparam logic [COUNT_W-1:0] WINDOW_RESET = 24'hFFFFFF;
  localparam logic [COUNT_W-1:0] WARN_RESET = 24'h000000;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 24'h000000;

  // ==========================================================
  // register map, byte addresses
  // ==========================================================
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TIMEOUT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FEED = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_WARN = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_WINDOW = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h20;

  // mode register fields
  localparam int MODE_EN_BIT = 0;
  localparam int MODE_RST_BIT = 1;
  localparam logic MODE_RST_RESET = 1'b1;

  // feed sequence bytes
  localparam logic [7:0] FEED_FIRST = 8'hAA;
  localparam logic [7:0] FEED_SECOND = 8'h55;

  // ==========================================================
  // carriers
  // ==========================================================
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } bus_req_t;

  // status, clear and enable share this layout, bit 4 first
  typedef struct packed {
    logic reset_flag;
    logic win_err;
    logic feed_err;
    logic warn;
    logic timeout;
  } events_t;

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic enable;
    logic reset_en;
    logic [COUNT_W-1:0] timeout;
    logic [COUNT_W-1:0] window;
    logic [COUNT_W-1:0] warn;
    logic [COUNT_W-1:0] count;
    logic fed_half;
    events_t status;
    events_t irq_en;
    logic irq;
    logic chip_rst;
  } wdt_state_t;

  localparam wdt_state_t STATE_RESET = '{
    waitreq: 1'b1, rdata: 32'h00000000, enable: 1'b0, reset_en: MODE_RST_RESET,
    timeout: TIMEOUT_RESET, window: WINDOW_RESET, warn: WARN_RESET,
    count: TIMEOUT_RESET, fed_half: 1'b0, status: 5'h00, irq_en: 5'h00,
    irq: 1'b0, chip_rst: 1'b0};

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [1:0] div;
    logic tick;
  } presc_state_t;

  // byte-enable merge of a write into a stored word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ---- watchdog_tick_prescaler.sv ----
`timescale 1ns/1ps
// ==========================================================
// count-clock synchroniser and divide-by-four prescaler
// ==========================================================
module watchdog_tick_prescaler (
  input wire logic clk,
  input wire logic reset,
  input wire logic wd_clock_pin,
  output logic tick
);

  wdt_pkg::presc_state_t s;
  wdt_pkg::presc_state_t next_s;

  // two flops before edge detect; only sync2 is looked at
  always_comb begin
    next_s = s;
    next_s.sync1 = wd_clock_pin;
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    next_s.tick = 1'b0;
    if (s.sync2 && !s.prev) begin
      next_s.div = s.div + 2'h1;
      if (s.div == wdt_pkg::PRESCALE_LAST) begin
        next_s.tick = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule

// ---- windowed_service_timer.sv ----
`timescale 1ns/1ps
module windowed_service_timer (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic [wdt_pkg::ADDR_W-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic WATCHDOG_COUNT_CLOCK,
  output logic IRQ,
  output logic CHIP_RESET
);

  // ==========================================================
  // state and carriers
  // ==========================================================
  wdt_pkg::wdt_state_t s;
  wdt_pkg::wdt_state_t next_s;
  wdt_pkg::bus_req_t req;
  wdt_pkg::events_t set_ev;
  wdt_pkg::events_t clr_ev;
  logic tick;
  logic take;
  logic fault;
  logic [31:0] merged;
  logic [31:0] mode_word;
  logic [wdt_pkg::COUNT_W-1:0] load_val;

  // bus pins bundled once so the decoder reads one carrier
  assign req = '{rd: READ, wr: WRITE, addr: ADDRESS, wdata: WRITEDATA, be: BYTEENABLE};

  // ==========================================================
  // prescaled tick from the dedicated oscillator
  // ==========================================================
  // separate count clock
  watchdog_tick_prescaler u_prescaler (
    .clk(MCLK),
    .reset(RESET),
    .wd_clock_pin(WATCHDOG_COUNT_CLOCK),
    .tick(tick)
  );

  // mode word as software sees it
  always_comb begin
    mode_word = 32'h00000000;
    mode_word[wdt_pkg::MODE_EN_BIT] = s.enable;
    mode_word[wdt_pkg::MODE_RST_BIT] = s.reset_en;
  end

  // ==========================================================
  // next-state logic
  // ==========================================================
  always_comb begin
    next_s = s;
    set_ev = '0;
    clr_ev = '0;
    fault = 1'b0;
    merged = 32'h00000000;
    load_val = wdt_pkg::TIMEOUT_MIN;
    next_s.chip_rst = 1'b0;
    next_s.waitreq = 1'b1;

    // a request is taken only while waitrequest stands high,
    // so the answer cycle never retakes the same request
    take = (req.rd || req.wr) && s.waitreq;

    // --------------------------------------------------------
    // counting
    // --------------------------------------------------------
    if (s.enable && tick) begin
      if (s.count == wdt_pkg::COUNT_ZERO) begin
        set_ev.timeout = 1'b1;
      end else begin
        next_s.count = s.count - 24'h000001;
        if (next_s.count == s.warn) begin
          set_ev.warn = 1'b1;
        end
      end
    end

    // --------------------------------------------------------
    // bus slave
    // --------------------------------------------------------
    if (take) begin
      next_s.waitreq = 1'b0;
      next_s.rdata = 32'h00000000;
      // any write elsewhere breaks a half-done feed
      if (req.wr && req.addr != wdt_pkg::OFS_FEED && s.fed_half) begin
        next_s.fed_half = 1'b0;
        if (s.enable) begin
          set_ev.feed_err = 1'b1;
        end
      end
      unique case (req.addr)
        wdt_pkg::OFS_MODE: begin
          next_s.rdata = mode_word;
          if (req.wr) begin
            merged = wdt_pkg::be_merge(mode_word, req.wdata, req.be);
            if (merged[wdt_pkg::MODE_EN_BIT] && !s.enable) begin
              next_s.enable = 1'b1;
              next_s.count = s.timeout;
            end
            // action is frozen while running
            if (!s.enable) begin
              next_s.reset_en = merged[wdt_pkg::MODE_RST_BIT];
            end
          end
        end
        wdt_pkg::OFS_TIMEOUT: begin
          next_s.rdata = {8'h00, s.timeout};
          if (req.wr) begin
            merged = wdt_pkg::be_merge({8'h00, s.timeout}, req.wdata, req.be);
            load_val = merged[wdt_pkg::COUNT_W-1:0];
            if (load_val < wdt_pkg::TIMEOUT_MIN) begin
              load_val = wdt_pkg::TIMEOUT_MIN;
            end
            next_s.timeout = load_val;
          end
        end
        wdt_pkg::OFS_FEED: begin
          // write-only: reads as zero
          if (req.wr && req.be[0]) begin
            if (req.wdata[7:0] == wdt_pkg::FEED_FIRST) begin
              next_s.fed_half = 1'b1;
            end else if (req.wdata[7:0] == wdt_pkg::FEED_SECOND && s.fed_half) begin
              next_s.fed_half = 1'b0;
              if (s.enable && s.count > s.window) begin
                set_ev.win_err = 1'b1;
              end else begin
                next_s.count = s.timeout;
              end
            end else begin
              next_s.fed_half = 1'b0;
              if (s.enable) begin
                set_ev.feed_err = 1'b1;
              end
            end
          end
        end
        wdt_pkg::OFS_COUNT: begin
          next_s.rdata = {8'h00, s.count};
        end
        wdt_pkg::OFS_WARN: begin
          next_s.rdata = {8'h00, s.warn};
          if (req.wr) begin
            merged = wdt_pkg::be_merge({8'h00, s.warn}, req.wdata, req.be);
            next_s.warn = merged[wdt_pkg::COUNT_W-1:0];
          end
        end
        wdt_pkg::OFS_WINDOW: begin
          next_s.rdata = {8'h00, s.window};
          if (req.wr) begin
            merged = wdt_pkg::be_merge({8'h00, s.window}, req.wdata, req.be);
            next_s.window = merged[wdt_pkg::COUNT_W-1:0];
          end
        end
        wdt_pkg::OFS_STATUS: begin
          next_s.rdata = {27'h0000000, s.status};
        end
        wdt_pkg::OFS_CLEAR: begin
          // write-one-to-clear, low byte only
          if (req.wr && req.be[0]) begin
            clr_ev = req.wdata[4:0];
          end
        end
        wdt_pkg::OFS_IRQ_EN: begin
          next_s.rdata = {27'h0000000, s.irq_en};
          if (req.wr && req.be[0]) begin
            next_s.irq_en = req.wdata[4:0];
          end
        end
        default: begin
          // unmapped: reads zero, writes dropped, still answered
          next_s.rdata = 32'h00000000;
        end
      endcase
    end

    // --------------------------------------------------------
    // fault action
    // --------------------------------------------------------
    fault = set_ev.timeout || set_ev.feed_err || set_ev.win_err;
    if (fault) begin
      next_s.enable = 1'b0;
      next_s.fed_half = 1'b0;
      next_s.count = s.timeout;
      if (s.reset_en) begin
        next_s.chip_rst = 1'b1;
        set_ev.reset_flag = 1'b1;
      end
    end

    // --------------------------------------------------------
    // sticky status and interrupt line
    // --------------------------------------------------------
    // a set in the clearing cycle wins, so no event is lost
    next_s.status = (s.status & ~clr_ev) | set_ev;
    next_s.irq = |(next_s.status & next_s.irq_en);
  end

  // ==========================================================
  // state register
  // ==========================================================
  // reset_flag also falls here: CHIP_RESET must not be routed
  // back into RESET, or the flag is lost before software reads it
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      s <= wdt_pkg::STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  // ==========================================================
  assign READDATA = s.rdata;
  assign WAITREQUEST = s.waitreq;
  assign IRQ = s.irq;
  assign CHIP_RESET = s.chip_rst;

endmodule

// ---- wdt_monitor.sv ----
`timescale 1ns/1ps
// ==========================================
// bus handshake and reset-output checks
module wdt_monitor (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic [wdt_pkg::ADDR_W-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  input wire logic IRQ,
  input wire logic CHIP_RESET
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  // a request is taken, then a one-cycle answer
  sequence s_take;
    (READ || WRITE) && WAITREQUEST;
  endsequence
  sequence s_answer;
    !WAITREQUEST ##1 WAITREQUEST;
  endsequence
  property p_handshake;
    s_take |=> s_answer;
  endproperty
  a_handshake: assert property (p_handshake) else $error("bus answer not one cycle");
  property p_idle;
    !(READ || WRITE) && WAITREQUEST |=> WAITREQUEST;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_cause;
    $fell(WAITREQUEST) |-> $past(READ || WRITE);
  endproperty
  a_cause: assert property (p_cause) else $error("waitrequest fell with no request");
  property p_rst_out;
    $fell(RESET) |-> WAITREQUEST && !IRQ && !CHIP_RESET;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
  // read data only move on a taken request
  property p_hold;
    !(READ || WRITE) |=> $stable(READDATA);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved while idle");
  property p_unmapped;
    READ && WAITREQUEST && ADDRESS == 8'h40 |=> READDATA == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_count_w;
    READ && WAITREQUEST && ADDRESS == wdt_pkg::OFS_COUNT |=> READDATA[31:24] == 8'h00;
  endproperty
  a_count_w: assert property (p_count_w) else $error("count wider than 24 bits");
  // a fault disables, so no second pulse soon after
  property p_pulse;
    CHIP_RESET |=> !CHIP_RESET [*3];
  endproperty
  a_pulse: assert property (p_pulse) else $error("chip reset not a lone pulse");
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
// ==========================================
// bench for the service timer
module tb_top;
  logic MCLK = 1'b0;
  logic RESET = 1'b1;
  logic [7:0] ADDRESS = 8'h00;
  logic READ = 1'b0;
  logic WRITE = 1'b0;
  logic [31:0] WRITEDATA = 32'h00000000;
  logic [31:0] READDATA;
  logic WAITREQUEST;
  logic IRQ;
  logic CHIP_RESET;
  logic [1:0] wdc = 2'h0;
  // lets a scenario hold the count still for an exact readback
  logic wd_run = 1'b1;
  logic [31:0] q;
  int n_fail = 0;
  int check_count = 0;
  int n_rst = 0;
  // 10 MHz bus clock
  always #50 MCLK = ~MCLK;
  // count clock at a quarter rate, two cycles high and low
  always @(posedge MCLK) if (wd_run) wdc <= wdc + 2'h1;
  // count chip reset pulses
  always @(posedge MCLK) if (CHIP_RESET === 1'b1) n_rst++;
  windowed_service_timer DUT (.MCLK(MCLK), .RESET(RESET), .ADDRESS(ADDRESS), .READ(READ),
    .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(4'hF), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .WATCHDOG_COUNT_CLOCK(wdc[1]), .IRQ(IRQ), .CHIP_RESET(CHIP_RESET));
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one bus cycle; held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge MCLK);
    READ <= ~w;
    WRITE <= w;
    ADDRESS <= a;
    WRITEDATA <= d;
    @(posedge MCLK);
    while (WAITREQUEST !== 1'b0 && i < 20) begin
      @(posedge MCLK);
      i++;
    end
    if (i == 20) begin
      n_fail++;
      summarize();
    end
    q = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h00000000);
    chk(nm, e, q);
  endtask
  task automatic t_regs;
    rdc(wdt_pkg::OFS_MODE, 32'h00000002, "mode");
    rdc(wdt_pkg::OFS_TIMEOUT, 32'h00FFFFFF, "timeout");
    rdc(wdt_pkg::OFS_STATUS, 32'h00000000, "status");
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    rdc(8'h40, 32'h00000000, "unmapped");
    bus(1'b1, wdt_pkg::OFS_COUNT, 32'h00000000);
    rdc(wdt_pkg::OFS_COUNT, 32'h00FFFFFF, "count");
    $display("t_regs done");
  endtask
  // warn masked, time-out unmasked, interrupt option only
  task automatic t_timeout;
    int i;
    bus(1'b1, wdt_pkg::OFS_IRQ_EN, 32'h00000001);
    bus(1'b1, wdt_pkg::OFS_TIMEOUT, 32'h00000010);
    rdc(wdt_pkg::OFS_TIMEOUT, 32'h000000FF, "clamp");
    bus(1'b1, wdt_pkg::OFS_MODE, 32'h00000001);
    bus(1'b1, wdt_pkg::OFS_MODE, 32'h00000000);
    rdc(wdt_pkg::OFS_MODE, 32'h00000001, "sticky");
    for (i = 0; i < 6000 && IRQ !== 1'b1; i++) @(negedge MCLK);
    if (i == 6000) begin
      n_fail++;
      summarize();
    end
    chk("irq", 32'h1, {31'h0, IRQ});
    rdc(wdt_pkg::OFS_STATUS, 32'h00000003, "tmo status");
    rdc(wdt_pkg::OFS_MODE, 32'h00000000, "fault off");
    chk("resets", 32'h0, n_rst);
    bus(1'b1, wdt_pkg::OFS_CLEAR, 32'h0000001F);
    chk("irq clr", 32'h0, {31'h0, IRQ});
    $display("t_timeout done");
  endtask
  // lone second feed byte with reset action set
  task automatic t_feed_err;
    bus(1'b1, wdt_pkg::OFS_MODE, 32'h00000003);
    bus(1'b1, wdt_pkg::OFS_FEED, 32'h00000055);
    rdc(wdt_pkg::OFS_STATUS, 32'h00000014, "feed fault");
    chk("resets", 32'h1, n_rst);
    bus(1'b1, wdt_pkg::OFS_CLEAR, 32'h0000001F);
    $display("t_feed_err done");
  endtask
  // early feed refused, then an in-window feed reloads
  task automatic t_window;
    bus(1'b1, wdt_pkg::OFS_WINDOW, 32'h00000080);
    bus(1'b1, wdt_pkg::OFS_MODE, 32'h00000001);
    bus(1'b1, wdt_pkg::OFS_FEED, 32'h000000AA);
    bus(1'b1, wdt_pkg::OFS_FEED, 32'h00000055);
    rdc(wdt_pkg::OFS_STATUS, 32'h00000008, "early feed");
    chk("resets", 32'h1, n_rst);
    bus(1'b1, wdt_pkg::OFS_CLEAR, 32'h0000001F);
    bus(1'b1, wdt_pkg::OFS_WINDOW, 32'h00FFFFFF);
    bus(1'b1, wdt_pkg::OFS_MODE, 32'h00000001);
    bus(1'b1, wdt_pkg::OFS_FEED, 32'h000000AA);
    rdc(wdt_pkg::OFS_STATUS, 32'h00000000, "mid feed");
    // freeze the count clock and let the prescaler pipeline drain
    wd_run <= 1'b0;
    repeat (8) @(posedge MCLK);
    bus(1'b1, wdt_pkg::OFS_FEED, 32'h00000055);
    rdc(wdt_pkg::OFS_COUNT, 32'h000000FF, "reload");
    wd_run <= 1'b1;
    rdc(wdt_pkg::OFS_STATUS, 32'h00000000, "good feed");
    $display("t_window done");
  endtask
  initial begin
    repeat (10) @(posedge MCLK);
    RESET <= 1'b0;
    t_regs();
    t_timeout();
    t_feed_err();
    t_window();
    summarize();
  end
endmodule
bind windowed_service_timer wdt_monitor u_mon (.MCLK(MCLK), .RESET(RESET), .ADDRESS(ADDRESS),
  .READ(READ), .WRITE(WRITE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .IRQ(IRQ),
  .CHIP_RESET(CHIP_RESET));
